// file: hw/ppr_consts.svh
// constants for the peripheral pin routing block
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH
`define PPR_ADDR_LCD_COM      8'haf
`define PPR_ADDR_TOUCH_SEL    8'hb3
`define PPR_ADDR_ROUTE_A      8'hb6
`define PPR_ADDR_ROUTE_B      8'hb7
`define PPR_RST_LCD_COM       4'h0
`define PPR_RST_TOUCH_CHOICE  2'h3
`define PPR_RST_ROUTE         8'h00
`define PPR_RST_PAD_CHOICE    1'b0
`define PPR_READ_ZERO         8'h00
`endif

// file: hw/ppr_pkg.sv
// types for the peripheral pin routing block
package ppr_pkg;
  typedef struct packed {
    logic ch4_route_port3_pin6;
    logic ch4_route_port1_pin5;
    logic ch4_route_port0_pin4;
    logic ch4_route_port0_pin0;
    logic ch3_route_port3_pin4;
    logic ch3_route_port1_pin0;
    logic ch2_route_port3_pin6;
    logic ch2_route_port1_pin1;
  } ppr_route_a_type;
  typedef struct packed {
    logic i2c_data_pad_choice;
    logic i2c_clock_pad_choice;
    logic ch6_route_port1_pin3;
    logic ch6_route_port0_pin7;
    logic ch6_route_port0_pin3;
    logic ch5_route_port1_pin4;
    logic ch5_route_port0_pin6;
    logic ch5_route_port0_pin1;
  } ppr_route_b_type;
  typedef struct packed {
    logic [1:0] touch_b_input_choice;
    logic [1:0] touch_a_input_choice;
  } ppr_touch_type;
  typedef struct packed {
    ppr_route_a_type route_a;
    ppr_route_b_type route_b;
    ppr_touch_type   touch;
    logic [3:0]      lcd_common_lines;
    logic [7:0]      rdata;
  } ppr_state_type;
  // per-pin overlay: output enable and value for each port bit
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] val;
  } ppr_port_type;
endpackage

// file: hw/ppr_pwm_route.sv
// pwm channel to port pin overlay
`timescale 1ns/10ps
module ppr_pwm_route (
  input  wire ppr_pkg::ppr_route_a_type route_a_i,
  input  wire ppr_pkg::ppr_route_b_type route_b_i,
  input  wire logic [6:2]               pwm_i,
  output ppr_pkg::ppr_port_type         p0_o,
  output ppr_pkg::ppr_port_type         p1_o,
  output ppr_pkg::ppr_port_type         p3_o
);
  always_comb begin
    p0_o = '0;
    p1_o = '0;
    p3_o = '0;
    // several enables of one channel drive all chosen pins
    p3_o.oe[6] = route_a_i.ch4_route_port3_pin6 |
                 route_a_i.ch2_route_port3_pin6;
    p3_o.val[6] = (route_a_i.ch4_route_port3_pin6 & pwm_i[4]) |
                  (route_a_i.ch2_route_port3_pin6 & pwm_i[2]);
    p1_o.oe[5] = route_a_i.ch4_route_port1_pin5;
    p1_o.val[5] = pwm_i[4];
    p0_o.oe[4] = route_a_i.ch4_route_port0_pin4;
    p0_o.val[4] = pwm_i[4];
    p0_o.oe[0] = route_a_i.ch4_route_port0_pin0;
    p0_o.val[0] = pwm_i[4];
    p3_o.oe[4] = route_a_i.ch3_route_port3_pin4;
    p3_o.val[4] = pwm_i[3];
    p1_o.oe[0] = route_a_i.ch3_route_port1_pin0;
    p1_o.val[0] = pwm_i[3];
    p1_o.oe[1] = route_a_i.ch2_route_port1_pin1;
    p1_o.val[1] = pwm_i[2];
    p1_o.oe[3] = route_b_i.ch6_route_port1_pin3;
    p1_o.val[3] = pwm_i[6];
    p0_o.oe[7] = route_b_i.ch6_route_port0_pin7;
    p0_o.val[7] = pwm_i[6];
    p0_o.oe[3] = route_b_i.ch6_route_port0_pin3;
    p0_o.val[3] = pwm_i[6];
    p1_o.oe[4] = route_b_i.ch5_route_port1_pin4;
    p1_o.val[4] = pwm_i[5];
    p0_o.oe[6] = route_b_i.ch5_route_port0_pin6;
    p0_o.val[6] = pwm_i[5];
    p0_o.oe[1] = route_b_i.ch5_route_port0_pin1;
    p0_o.val[1] = pwm_i[5];
    // a pin with no route set must not see the waveform
    p0_o.val = p0_o.val & p0_o.oe;
    p1_o.val = p1_o.val & p1_o.oe;
    p3_o.val = p3_o.val & p3_o.oe;
  end
endmodule

// file: hw/ppr_touch_mux.sv
// touch key input channel selection
`timescale 1ns/10ps
module ppr_touch_mux (
  input  wire ppr_pkg::ppr_touch_type touch_i,
  input  wire logic [7:0]             p0_in_i,
  input  wire logic [7:0]             p1_in_i,
  input  wire logic [7:0]             p2_in_i,
  input  wire logic [7:0]             p3_in_i,
  output logic                        touch_a_o,
  output logic                        touch_b_o
);
  always_comb begin
    case (touch_i.touch_a_input_choice)
      2'h0:    touch_a_o = p3_in_i[7];
      2'h1:    touch_a_o = p2_in_i[1];
      2'h2:    touch_a_o = p2_in_i[0];
      default: touch_a_o = p1_in_i[2];
    endcase
    case (touch_i.touch_b_input_choice)
      2'h0:    touch_b_o = p1_in_i[1];
      2'h1:    touch_b_o = p0_in_i[5];
      2'h2:    touch_b_o = p0_in_i[6];
      default: touch_b_o = p0_in_i[7];
    endcase
  end
endmodule

// file: hw/ppr_pin_routing.sv
// peripheral pin routing: registers and pad overlays
`timescale 1ns/10ps
`include "ppr_consts.svh"
// Function
// - four bits each route pwm channel 4 to P3.6, P1.5, P0.4 or P0.0.
// - two bits each route pwm channel 3 to P3.4 or P1.0.
// - two bits each route pwm channel 2 to P3.6 or P1.1.
// - three bits each route pwm channel 6 to P1.3, P0.7 and P0.3.
// - three bits each route pwm channel 5 to P1.4, P0.6 and P0.1.
// - bit 7 puts i2c data on P3.5 when 0 or P1.6 when 1, reset 0.
// - bit 6 puts i2c clock on P1.3 when 0 or P0.2 when 1, reset 0.
// - touch b choice in bits 5:4 picks P1.1, P0.5, P0.6, P0.7, reset 11.
// - touch a choice in bits 1:0 picks P3.7, P2.1, P2.0, P1.2, reset 11.
// - bits 3:0 enable lcd half-bias common outputs on P1.5 to P1.2.
module ppr_pin_routing (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  input  wire logic [6:2] pwm_i,
  input  wire logic [7:0] p0_in_i,
  input  wire logic [7:0] p1_in_i,
  input  wire logic [7:0] p2_in_i,
  input  wire logic [7:0] p3_in_i,
  input  wire logic [7:0] p0_port_out_i,
  input  wire logic [7:0] p0_port_oe_i,
  input  wire logic [7:0] p1_port_out_i,
  input  wire logic [7:0] p1_port_oe_i,
  input  wire logic [7:0] p3_port_out_i,
  input  wire logic [7:0] p3_port_oe_i,
  output logic [7:0]      p0_out_o,
  output logic [7:0]      p0_oe_o,
  output logic [7:0]      p1_out_o,
  output logic [7:0]      p1_oe_o,
  output logic [7:0]      p3_out_o,
  output logic [7:0]      p3_oe_o,
  input  wire logic       i2c_sda_out_i,
  input  wire logic       i2c_sda_oe_i,
  input  wire logic       i2c_scl_out_i,
  input  wire logic       i2c_scl_oe_i,
  output logic            i2c_sda_in_o,
  output logic            i2c_scl_in_o,
  input  wire logic [3:0] lcd_com_out_i,
  input  wire logic [3:0] lcd_com_oe_i,
  output logic [3:0]      lcd_com_bias_en_o,
  output logic            touch_a_o,
  output logic            touch_b_o
);
  ppr_pkg::ppr_state_type state;
  ppr_pkg::ppr_state_type next_state;
  ppr_pkg::ppr_port_type  pwm_p0;
  ppr_pkg::ppr_port_type  pwm_p1;
  ppr_pkg::ppr_port_type  pwm_p3;

  // registers and read path
  always_comb begin
    next_state = state;
    next_state.rdata = `PPR_READ_ZERO;
    if (wr_i) begin
      if (addr_i == `PPR_ADDR_LCD_COM) begin
        next_state.lcd_common_lines = wdata_i[3:0];
      end else if (addr_i == `PPR_ADDR_TOUCH_SEL) begin
        next_state.touch.touch_b_input_choice = wdata_i[5:4];
        next_state.touch.touch_a_input_choice = wdata_i[1:0];
      end else if (addr_i == `PPR_ADDR_ROUTE_A) begin
        next_state.route_a = wdata_i;
      end else if (addr_i == `PPR_ADDR_ROUTE_B) begin
        next_state.route_b = wdata_i;
      end
    end
    if (rd_i) begin
      if (addr_i == `PPR_ADDR_LCD_COM) begin
        next_state.rdata = {4'h0, state.lcd_common_lines};
      end else if (addr_i == `PPR_ADDR_TOUCH_SEL) begin
        next_state.rdata = {2'h0, state.touch.touch_b_input_choice,
                            2'h0, state.touch.touch_a_input_choice};
      end else if (addr_i == `PPR_ADDR_ROUTE_A) begin
        next_state.rdata = state.route_a;
      end else if (addr_i == `PPR_ADDR_ROUTE_B) begin
        next_state.rdata = state.route_b;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state.route_a <= `PPR_RST_ROUTE;
      state.route_b <= `PPR_RST_ROUTE;
      state.route_b.i2c_data_pad_choice <= `PPR_RST_PAD_CHOICE;
      state.route_b.i2c_clock_pad_choice <= `PPR_RST_PAD_CHOICE;
      state.touch.touch_b_input_choice <= `PPR_RST_TOUCH_CHOICE;
      state.touch.touch_a_input_choice <= `PPR_RST_TOUCH_CHOICE;
      state.lcd_common_lines <= `PPR_RST_LCD_COM;
      state.rdata <= `PPR_READ_ZERO;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_o = state.rdata;
  assign lcd_com_bias_en_o = state.lcd_common_lines;

  ppr_pwm_route u_pwm_route (
    .route_a_i (state.route_a),
    .route_b_i (state.route_b),
    .pwm_i     (pwm_i),
    .p0_o      (pwm_p0),
    .p1_o      (pwm_p1),
    .p3_o      (pwm_p3)
  );

  ppr_touch_mux u_touch_mux (
    .touch_i   (state.touch),
    .p0_in_i   (p0_in_i),
    .p1_in_i   (p1_in_i),
    .p2_in_i   (p2_in_i),
    .p3_in_i   (p3_in_i),
    .touch_a_o (touch_a_o),
    .touch_b_o (touch_b_o)
  );

  // pad overlay: i2c, lcd common, pwm, else ordinary port
  always_comb begin
    logic sda_sel;
    logic scl_sel;
    sda_sel = state.route_b.i2c_data_pad_choice;
    scl_sel = state.route_b.i2c_clock_pad_choice;
    // unselected pins keep their ordinary port function
    p0_out_o = (p0_port_out_i & ~pwm_p0.oe) | pwm_p0.val;
    p0_oe_o  = p0_port_oe_i | pwm_p0.oe;
    p1_out_o = (p1_port_out_i & ~pwm_p1.oe) | pwm_p1.val;
    p1_oe_o  = p1_port_oe_i | pwm_p1.oe;
    p3_out_o = (p3_port_out_i & ~pwm_p3.oe) | pwm_p3.val;
    p3_oe_o  = p3_port_oe_i | pwm_p3.oe;
    for (int i = 0; i < 4; i++) begin
      if (state.lcd_common_lines[i]) begin
        p1_out_o[i+2] = lcd_com_out_i[i];
        p1_oe_o[i+2]  = lcd_com_oe_i[i];
      end
    end
    if (sda_sel) begin
      p1_out_o[6] = i2c_sda_out_i;
      p1_oe_o[6]  = i2c_sda_oe_i;
      i2c_sda_in_o = p1_in_i[6];
    end else begin
      p3_out_o[5] = i2c_sda_out_i;
      p3_oe_o[5]  = i2c_sda_oe_i;
      i2c_sda_in_o = p3_in_i[5];
    end
    if (scl_sel) begin
      p0_out_o[2] = i2c_scl_out_i;
      p0_oe_o[2]  = i2c_scl_oe_i;
      i2c_scl_in_o = p0_in_i[2];
    end else begin
      p1_out_o[3] = i2c_scl_out_i;
      p1_oe_o[3]  = i2c_scl_oe_i;
      i2c_scl_in_o = p1_in_i[3];
    end
  end
endmodule

// file: tb/ppr_pin_routing_chk.sv
// port assertions for the pin routing block
`timescale 1ns/10ps
module ppr_pin_routing_chk (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic [6:2] pwm_i,
  input wire logic [7:0] p0_in_i,
  input wire logic [7:0] p1_in_i,
  input wire logic [7:0] p2_in_i,
  input wire logic [7:0] p3_in_i,
  input wire logic [7:0] p0_port_out_i,
  input wire logic [7:0] p0_port_oe_i,
  input wire logic [7:0] p0_out_o,
  input wire logic [7:0] p0_oe_o,
  input wire logic [7:0] p3_out_o,
  input wire logic [7:0] p3_oe_o,
  input wire logic       i2c_sda_in_o,
  input wire logic       i2c_scl_in_o,
  input wire logic [3:0] lcd_com_bias_en_o,
  input wire logic       touch_a_o,
  input wire logic       touch_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] wq;
  wire  [3:0] ta = {p1_in_i[2], p2_in_i[0], p2_in_i[1], p3_in_i[7]};
  wire  [3:0] tb = {p0_in_i[7], p0_in_i[6], p0_in_i[5], p1_in_i[1]};
  always_ff @(posedge clk_i) wq <= wdata_i;
  sequence wr_at(logic [7:0] a);
    wr_i && addr_i == a;
  endsequence
  sda_low_a: assert property (wr_at(8'hb7) ##0 !wdata_i[7] |=>
    i2c_sda_in_o == p3_in_i[5]) else $error("sda pad wrong");
  sda_high_a: assert property (wr_at(8'hb7) ##0 wdata_i[7] |=>
    i2c_sda_in_o == p1_in_i[6]) else $error("sda pad wrong");
  scl_low_a: assert property (wr_at(8'hb7) ##0 !wdata_i[6] |=>
    i2c_scl_in_o == p1_in_i[3]) else $error("scl pad wrong");
  scl_high_a: assert property (wr_at(8'hb7) ##0 wdata_i[6] |=>
    i2c_scl_in_o == p0_in_i[2]) else $error("scl pad wrong");
  touch_a_a: assert property (wr_at(8'hb3) |=>
    touch_a_o == ta[wq[1:0]]) else $error("touch a pad wrong");
  touch_b_a: assert property (wr_at(8'hb3) |=>
    touch_b_o == tb[wq[5:4]]) else $error("touch b pad wrong");
  lcd_en_a: assert property (wr_at(8'haf) |=>
    lcd_com_bias_en_o == wq[3:0]) else $error("lcd enable wrong");
  ch4_route_a: assert property (wr_at(8'hb6) ##0 wdata_i[4] |=>
    p0_oe_o[0] && p0_out_o[0] == pwm_i[4]) else $error("ch4 route wrong");
  ch3_route_a: assert property (wr_at(8'hb6) ##0 wdata_i[3] |=>
    p3_oe_o[4] && p3_out_o[4] == pwm_i[3]) else $error("ch3 route wrong");
  ch5_route_a: assert property (wr_at(8'hb7) ##0 wdata_i[0] |=>
    p0_oe_o[1] && p0_out_o[1] == pwm_i[5]) else $error("ch5 route wrong");
  port_keep_a: assert property (wr_at(8'hb6) ##0 !wdata_i[4] |=>
    {p0_out_o[0], p0_oe_o[0]} == {p0_port_out_i[0], p0_port_oe_i[0]})
    else $error("port function lost");
endmodule
bind ppr_pin_routing ppr_pin_routing_chk u_chk (.*);

// file: tb/ppr_pin_routing_tb.sv
// self-checking bench for the pin routing block
`timescale 1ns/10ps
module ppr_pin_routing_tb;
  logic       clk_i, resetn_i, wr_i, rd_i, touch_a_o, touch_b_o;
  logic [7:0] addr_i, wdata_i, rdata_o, p0_in_i, p1_in_i, p2_in_i, p3_in_i;
  logic [7:0] p0_port_out_i, p0_port_oe_i, p1_port_out_i, p1_port_oe_i;
  logic [7:0] p3_port_out_i, p3_port_oe_i, p0_out_o, p0_oe_o, p1_out_o;
  logic [7:0] p1_oe_o, p3_out_o, p3_oe_o, ra, rb, rt, rl;
  logic [6:2] pwm_i;
  logic       i2c_sda_out_i, i2c_sda_oe_i, i2c_scl_out_i, i2c_scl_oe_i;
  logic       i2c_sda_in_o, i2c_scl_in_o;
  logic [3:0] lcd_com_out_i, lcd_com_oe_i, lcd_com_bias_en_o;
  logic [31:0] seed = 32'h5a;
  logic [7:0] ads [5] = '{8'hb6, 8'hb7, 8'hb3, 8'haf, 8'ha0};
  int         error_cnt, num_checks;
  ppr_pin_routing DUT (.*);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] pads_exp();
    logic [3:0] ta;
    logic [3:0] tb;
    ta = {p1_in_i[2], p2_in_i[0], p2_in_i[1], p3_in_i[7]};
    tb = {p0_in_i[7], p0_in_i[6], p0_in_i[5], p1_in_i[1]};
    return {ta[rt[1:0]], tb[rt[5:4]], rb[7] ? p1_in_i[6] : p3_in_i[5],
      rb[6] ? p0_in_i[2] : p1_in_i[3],
      ra[4] ? {pwm_i[4], 1'b1} : {p0_port_out_i[0], p0_port_oe_i[0]},
      rb[0] ? {pwm_i[5], 1'b1} : {p0_port_out_i[1], p0_port_oe_i[1]}};
  endfunction
  function automatic logic [47:0] pins_exp();
    logic [7:0] m0, m1, m3, o0, o1, o3, e0, e1, e3;
    m0 = {rb[4], rb[1], 1'b0, ra[5], rb[3], 1'b0, rb[0], ra[4]};
    m1 = {2'b00, ra[6], rb[2], rb[5], 1'b0, ra[0], ra[2]};
    m3 = {1'b0, ra[7] | ra[1], 1'b0, ra[3], 4'h0};
    o0 = (p0_port_out_i & ~m0) | (m0 & {pwm_i[6], pwm_i[5], 1'b0,
      pwm_i[4], pwm_i[6], 1'b0, pwm_i[5], pwm_i[4]});
    o1 = (p1_port_out_i & ~m1) | (m1 & {2'b00, pwm_i[4], pwm_i[5],
      pwm_i[6], 1'b0, pwm_i[2], pwm_i[3]});
    o3 = (p3_port_out_i & ~m3) |
      {1'b0, (ra[7] & pwm_i[4]) | (ra[1] & pwm_i[2]), 1'b0,
      ra[3] & pwm_i[3], 4'h0};
    e0 = p0_port_oe_i | m0;
    e1 = p1_port_oe_i | m1;
    e3 = p3_port_oe_i | m3;
    for (int k = 0; k < 4; k++) begin
      if (rl[k]) begin
        o1[k+2] = lcd_com_out_i[k];
        e1[k+2] = lcd_com_oe_i[k];
      end
    end
    if (rb[7]) begin
      {o1[6], e1[6]} = {i2c_sda_out_i, i2c_sda_oe_i};
    end else begin
      {o3[5], e3[5]} = {i2c_sda_out_i, i2c_sda_oe_i};
    end
    if (rb[6]) begin
      {o0[2], e0[2]} = {i2c_scl_out_i, i2c_scl_oe_i};
    end else begin
      {o1[3], e1[3]} = {i2c_scl_out_i, i2c_scl_oe_i};
    end
    return {o0, e0, o1, e1, o3, e3};
  endfunction
  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rnd_in();
    {p0_in_i, p1_in_i, p2_in_i, p3_in_i} <= xs();
    {p0_port_out_i, p0_port_oe_i, p1_port_out_i, p1_port_oe_i} <= xs();
    {p3_port_out_i, p3_port_oe_i, lcd_com_out_i, lcd_com_oe_i, pwm_i,
      i2c_sda_out_i, i2c_sda_oe_i, i2c_scl_out_i} <= xs();
    i2c_scl_oe_i <= seed[3];
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check("rdata", rdata_o, e);
  endtask
  task automatic pads();
    logic [47:0] pe;
    @(posedge clk_i);
    rnd_in();
    #1 check("pads", {touch_a_o, touch_b_o, i2c_sda_in_o, i2c_scl_in_o,
      p0_out_o[0], p0_oe_o[0], p0_out_o[1], p0_oe_o[1]}, pads_exp());
    check("lcd", {4'h0, lcd_com_bias_en_o}, {4'h0, rl[3:0]});
    pe = pins_exp();
    check("p0_out", p0_out_o, pe[47:40]);
    check("p0_oe", p0_oe_o, pe[39:32]);
    check("p1_out", p1_out_o, pe[31:24]);
    check("p1_oe", p1_oe_o, pe[23:16]);
    check("p3_out", p3_out_o, pe[15:8]);
    check("p3_oe", p3_oe_o, pe[7:0]);
  endtask
  // watchdog: about 40 tests of some 13 cycles each, with wide margin
  initial begin
    #100us;
    error_cnt++;
    results();
  end
  initial begin
    {resetn_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    rnd_in();
    {ra, rb, rt, rl} = {8'h00, 8'h00, 8'h33, 8'h00};
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    pads();
    for (int i = 0; i < 40; i++) begin
      logic [7:0] v;
      v = (i < 5) ? 8'hff : ((i < 10) ? 8'h00 : 8'(xs()));
      case (i % 5)
        0: ra = v;
        1: rb = v;
        2: rt = v & 8'h33;
        3: rl = v & 8'h0f;
        default: ;
      endcase
      wr(ads[i % 5], v);
      pads();
      rd(8'hb6, ra);
      rd(8'hb7, rb);
      rd(8'hb3, rt);
      rd(8'haf, rl);
      rd(8'ha0, 8'h00);
      $display("test %0d done", i);
    end
    results();
  end
endmodule
